// [rtl/ookrx_pkg.sv]
package ookrx_pkg;
  // ==========================================================
  // register map: printed offsets used as addresses
  localparam logic [31:0] ADDR_BUF_FIRST = 32'h5000_0020;
  localparam logic [31:0] ADDR_BUF_LAST  = 32'h5000_0029;
  localparam logic [31:0] ADDR_BIT_COUNT = 32'h5000_002a;
  localparam logic [31:0] ADDR_STATUS    = 32'h5000_002b;
  localparam logic [31:0] ADDR_MIN_LEN   = 32'h5001_1000;
  localparam logic [31:0] ADDR_GAIN      = 32'h5001_1001;
  localparam logic [31:0] ADDR_SLICER    = 32'h5001_1002;
  localparam logic [31:0] ADDR_SYSTIME   = 32'h5001_1003;
  localparam logic [31:0] ADDR_DCD_LO    = 32'h5001_1004;
  localparam logic [31:0] ADDR_DCD_HI    = 32'h5001_1005;
  localparam logic [31:0] ADDR_SNIFF     = 32'h5001_1006;
  localparam logic [31:0] ADDR_GAIN_MON  = 32'h5001_1007;

  // ==========================================================
  // values after reset
  localparam logic [7:0]  RST_MIN_LEN = 8'h28;
  localparam logic [7:0]  RST_GAIN    = 8'h98;
  localparam logic [7:0]  RST_SLICER  = 8'hab;
  localparam logic [7:0]  RST_SYSTIME = 8'h5a;
  localparam logic [15:0] RST_DCD     = 16'h3614;
  localparam logic [7:0]  RST_SNIFF   = 8'h0b;

  // ==========================================================
  // status field positions and buffer size
  localparam int ST_ON    = 7;
  localparam int ST_SNIFF = 6;
  localparam int ST_READY = 5;
  localparam int ST_LONG  = 3;
  localparam int ST_LEVEL = 2;
  localparam logic [6:0] BUF_FULL = 7'h50;

  // ==========================================================
  // timing: one crystal tick is fxo/64
  localparam longint CLK_HZ = 250_000_000;
  localparam longint XO_HZ  = 3_579_545;
  localparam longint XO_DIV = 64;
  localparam int XO_TICK_CYCLES = int'((CLK_HZ * XO_DIV) / XO_HZ);
  localparam logic [17:0] LISTEN_TICKS = 18'h00040;
  localparam logic [3:0][7:0] FAST_TAB  = {8'h40, 8'h30, 8'h20, 8'h01};
  localparam logic [3:0][7:0] SYNTH_TAB = {8'h80, 8'h40, 8'h30, 8'h20};
  localparam logic [7:0][7:0] SLEEP_TAB =
    {8'h80, 8'h20, 8'h0e, 8'h0c, 8'h0a, 8'h08, 8'h06, 8'h04};
  localparam logic [7:0][7:0] WAKE_TAB =
    {8'h20, 8'h18, 8'h12, 8'h10, 8'h0e, 8'h0c, 8'h0a, 8'h08};
  localparam logic [3:0][4:0] DEC_TAB = {5'h10, 5'h0f, 5'h0e, 5'h0d};

  // ==========================================================
  // state machines
  typedef enum logic [6:0] {
    D_IDLE = 7'h01, D_HUNT = 7'h02, D_GUARD = 7'h04, D_HIGH = 7'h08,
    D_LOW  = 7'h10, D_WAITGB = 7'h20, D_ARMED = 7'h40
  } ookrx_dec_t;
  typedef enum logic [6:0] {
    S_OFF    = 7'h01, S_SYNTH = 7'h02, S_FAST  = 7'h04, S_RUN = 7'h08,
    S_LISTEN = 7'h10, S_AWAKE = 7'h20, S_SLEEP = 7'h40
  } ookrx_seq_t;
endpackage : ookrx_pkg

// [rtl/ookrx_tick.sv]
`timescale 1ns/1ps
module ookrx_tick #(
  parameter int XO_CYCLES = ookrx_pkg::XO_TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [1:0]  dec_sel,
  input  wire logic        mag_valid,
  input  wire logic [15:0] mag_sample,
  output logic             xo_tick,
  output logic             dec_tick,
  output logic [15:0]      dec_sample
);
  import ookrx_pkg::*;

  typedef struct packed {
    logic [12:0] xo_cnt;
    logic        xo_tick;
    logic [4:0]  dec_cnt;
    logic [19:0] acc;
    logic        dec_tick;
    logic [15:0] dec_sample;
  } ookrx_tick_t;

  ookrx_tick_t s_ff;
  ookrx_tick_t nxt_s;

  // ==========================================================
  // crystal tick divider and accumulate-and-dump decimator
  always_comb begin
    logic [19:0] sum;
    sum = s_ff.acc + {4'h0, mag_sample};
    nxt_s = s_ff;
    nxt_s.xo_tick = 1'b0;
    nxt_s.dec_tick = 1'b0;
    if (s_ff.xo_cnt == 13'(XO_CYCLES - 1)) begin
      nxt_s.xo_cnt = 13'h0000;
      nxt_s.xo_tick = 1'b1;
    end else begin
      nxt_s.xo_cnt = s_ff.xo_cnt + 13'h0001;
    end
    if (mag_valid) begin
      if (s_ff.dec_cnt == DEC_TAB[dec_sel] - 5'h01) begin
        nxt_s.dec_cnt = 5'h00;
        nxt_s.acc = 20'h00000;
        nxt_s.dec_tick = 1'b1;
        nxt_s.dec_sample = sum[19:4];
      end else begin
        nxt_s.dec_cnt = s_ff.dec_cnt + 5'h01;
        nxt_s.acc = sum;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign xo_tick    = s_ff.xo_tick;
  assign dec_tick   = s_ff.dec_tick;
  assign dec_sample = s_ff.dec_sample;
endmodule : ookrx_tick

// [rtl/ookrx_slicer.sv]
`timescale 1ns/1ps
module ookrx_slicer (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        run,
  input  wire logic        fast_bias,
  input  wire logic        dec_tick,
  input  wire logic [15:0] dec_sample,
  input  wire logic [1:0]  decay_coeff,
  input  wire logic [1:0]  attack_coeff,
  output logic             slicer_bit
);
  import ookrx_pkg::*;

  typedef struct packed {
    logic [15:0] level;
    logic        bit_q;
  } ookrx_slc_t;

  ookrx_slc_t s_ff;
  ookrx_slc_t nxt_s;

  // ==========================================================
  // peak level: fast attack above it, slow decay below it
  always_comb begin
    logic [15:0] diff;
    logic [3:0]  shamt;
    diff = 16'h0000;
    shamt = 4'({2'b00, attack_coeff}) + 4'h1;
    nxt_s = s_ff;
    if (!run) begin
      nxt_s = '0;
    end else if (dec_tick) begin
      if (dec_sample > s_ff.level) begin
        diff = dec_sample - s_ff.level;
        nxt_s.level = s_ff.level + (diff >> shamt);
      end else begin
        diff = s_ff.level - dec_sample;
        if (!fast_bias) begin
          shamt = 4'({2'b00, decay_coeff}) + 4'h8;
        end
        nxt_s.level = s_ff.level - (diff >> shamt);
      end
      nxt_s.bit_q = dec_sample > {1'b0, s_ff.level[15:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign slicer_bit = s_ff.bit_q;
endmodule : ookrx_slicer

// [rtl/ookrx_core.sv]
// Contract
// - decoded bits shift in at bit 0, older bits move upward
// - read-only seven-bit count of bits held in the buffer
// - full valid message raises interrupt and arms with decoder halted
// - edge/level select picks transitions on edges or on levels
// - message valid only with at least the minimum bit count
// - half-rate select counts bit timing at half rate
// - fixed gain drives trim directly; auto gain starts and steps
// - level decays by 1/256 to 1/2048 inside slicer levels
// - fast-bias interval of 1, 32, 48 or 64 crystal ticks
// - decimation factor 13, 14, 15 or 16
// - synthesizer bias wait of 32, 48, 64 or 128 ticks
// - sniff sleep of 4 to 128 times 1024 ticks
// - stay awake 8 to 32 times 1024 ticks after guard band
// - element thresholds are cumulative minimum, maximum and guard counts
// - sniff checks first N elements, sleeps again on a mistimed one; listen wakes on the first guard band before any element
// - duty-cycled sniff mode selectable instead of continuous mode
// - control registers return to presets on reset
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module ookrx_core #(
  parameter int XO_TICK_CYCLES = ookrx_pkg::XO_TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [31:0] addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [7:0]       rd_data,
  input  wire logic        mag_valid,
  input  wire logic [15:0] mag_sample,
  input  wire logic        gain_overflow_pin,
  output logic             msg_irq,
  output logic [6:0]       gain_trim,
  output logic             analog_on,
  output logic             receiver_asleep,
  output logic             rt_out
);
  import ookrx_pkg::*;

  typedef struct packed {
    logic        on;
    logic        sniff;
    logic        long_mode;
    logic        level_mode;
    logic [7:0]  min_len;
    logic [7:0]  gain;
    logic [7:0]  slc;
    logic [7:0]  systime;
    logic [15:0] dcd;
    logic [7:0]  sniffc;
    logic [79:0] rx_bits;
    logic [6:0]  cnt;
    logic        govf;
    logic [7:0]  rdata;
    ookrx_dec_t  dst;
    logic [7:0]  dlen;
    logic [7:0]  hi_len;
    logic        half;
    logic        prev_slc;
    ookrx_seq_t  sst;
    logic [17:0] scnt;
    logic [3:0]  edges;
    logic [3:0]  gidx;
    logic [6:0]  trim;
    logic        ovf_s1;
    logic        ovf_s2;
    logic        ovf_prev;
    logic        aon;
    logic        asleep;
    logic        irq;
    logic        rt;
  } ookrx_state_t;

  ookrx_state_t s_ff;
  ookrx_state_t nxt_s;

  logic        xo_tick;
  logic        dec_tick;
  logic [15:0] dec_sample;
  logic        slicer_bit;
  logic        slc_run;
  logic        sample;
  logic        rise;
  logic        fall;
  logic        bit_ev;
  logic        bit_val;
  logic        err_ev;
  logic        guard_ev;
  logic        ok_ev;
  logic        release_ev;
  logic        dec_run;
  logic        tmo;
  logic        ovf_ev;
  logic        gain_wr;
  logic        gb_hit;
  logic        in_win;
  logic [7:0]  len_inc;
  logic [7:0]  t_min;
  logic [7:0]  t_max;
  logic [7:0]  t_gb;

  // ==========================================================
  // timing sources and slicer
  ookrx_tick #(
    .XO_CYCLES (XO_TICK_CYCLES)
  ) u_tick (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .dec_sel    (s_ff.slc[1:0]),
    .mag_valid  (mag_valid),
    .mag_sample (mag_sample),
    .xo_tick    (xo_tick),
    .dec_tick   (dec_tick),
    .dec_sample (dec_sample)
  );

  assign slc_run = s_ff.sst == S_FAST || dec_run;

  ookrx_slicer u_slicer (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .run          (slc_run),
    .fast_bias    (s_ff.sst == S_FAST),
    .dec_tick     (dec_tick),
    .dec_sample   (dec_sample),
    .decay_coeff  (s_ff.slc[7:6]),
    .attack_coeff (s_ff.slc[5:4]),
    .slicer_bit   (slicer_bit)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    nxt_s = s_ff;
    bit_ev = 1'b0;
    bit_val = 1'b0;
    err_ev = 1'b0;
    guard_ev = 1'b0;
    ok_ev = 1'b0;
    release_ev = 1'b0;
    gain_wr = 1'b0;
    dec_run = s_ff.sst == S_RUN || s_ff.sst == S_LISTEN
           || s_ff.sst == S_AWAKE;
    // cumulative thresholds in decimated samples
    t_min = {4'h0, s_ff.dcd[15:12]} + 8'h01;
    t_max = t_min + {2'b00, s_ff.dcd[11:6]};
    t_gb  = t_max + {2'b00, s_ff.dcd[5:0]};

    // register writes
    if (wr_en) begin
      case (addr)
        ADDR_STATUS: begin
          nxt_s.on = wr_data[ST_ON];
          nxt_s.sniff = wr_data[ST_SNIFF];
          nxt_s.long_mode = wr_data[ST_LONG];
          nxt_s.level_mode = wr_data[ST_LEVEL];
          release_ev = s_ff.dst == D_ARMED && !wr_data[ST_READY];
        end
        ADDR_MIN_LEN: nxt_s.min_len = wr_data;
        ADDR_GAIN: begin
          nxt_s.gain = wr_data;
          gain_wr = 1'b1;
        end
        ADDR_SLICER:  nxt_s.slc = wr_data;
        ADDR_SYSTIME: nxt_s.systime = wr_data;
        ADDR_DCD_LO:  nxt_s.dcd[7:0] = wr_data;
        ADDR_DCD_HI:  nxt_s.dcd[15:8] = wr_data;
        ADDR_SNIFF:   nxt_s.sniffc = {wr_data[7:5], 1'b0, wr_data[3:0]};
        default: ;
      endcase
    end

    // register reads, data stand in the next cycle
    nxt_s.rdata = 8'h00;
    if (rd_en) begin
      case (addr)
        ADDR_BIT_COUNT: nxt_s.rdata = {1'b0, s_ff.cnt};
        ADDR_STATUS: begin
          nxt_s.rdata = {s_ff.on, s_ff.sniff, s_ff.dst == D_ARMED,
                         s_ff.govf, s_ff.long_mode, s_ff.level_mode,
                         slicer_bit, s_ff.asleep};
          nxt_s.govf = 1'b0;
        end
        ADDR_MIN_LEN:  nxt_s.rdata = s_ff.min_len;
        ADDR_GAIN:     nxt_s.rdata = s_ff.gain;
        ADDR_SLICER:   nxt_s.rdata = s_ff.slc;
        ADDR_SYSTIME:  nxt_s.rdata = s_ff.systime;
        ADDR_DCD_LO:   nxt_s.rdata = s_ff.dcd[7:0];
        ADDR_DCD_HI:   nxt_s.rdata = s_ff.dcd[15:8];
        ADDR_SNIFF:    nxt_s.rdata = s_ff.sniffc;
        ADDR_GAIN_MON: nxt_s.rdata = {1'b0, s_ff.trim};
        default: begin
          if (addr >= ADDR_BUF_FIRST && addr <= ADDR_BUF_LAST) begin
            nxt_s.rdata = s_ff.rx_bits[{addr[3:0], 3'b000} +: 8];
          end
        end
      endcase
    end

    // element timing, counted at half rate when selected
    sample = dec_tick && (!s_ff.min_len[7] || s_ff.half);
    if (dec_tick) begin
      nxt_s.half = ~s_ff.half;
    end
    rise = sample && slicer_bit && !s_ff.prev_slc;
    fall = sample && !slicer_bit && s_ff.prev_slc;
    len_inc = (s_ff.dlen == 8'hff) ? s_ff.dlen : s_ff.dlen + 8'h01;
    if (sample) begin
      nxt_s.prev_slc = slicer_bit;
      nxt_s.dlen = (rise || fall) ? 8'h00 : len_inc;
    end
    in_win = s_ff.dlen >= t_min && s_ff.dlen <= t_max;
    // guard band on a level, or at the rising edge that ends it
    if (s_ff.level_mode) begin
      gb_hit = sample && !slicer_bit && len_inc == t_gb;
    end else begin
      gb_hit = rise && s_ff.dlen >= t_gb;
    end

    // decoder
    case (s_ff.dst)
      D_IDLE: begin
        if (dec_run) begin
          nxt_s.dst = D_HUNT;
        end
      end
      D_HUNT, D_WAITGB: begin
        guard_ev = gb_hit;
      end
      D_GUARD: begin
        if (rise) begin
          nxt_s.dst = D_HIGH;
        end
      end
      D_HIGH: begin
        if (s_ff.level_mode && sample && slicer_bit
            && len_inc > t_max) begin
          err_ev = 1'b1;
        end else if (fall) begin
          if (in_win) begin
            nxt_s.hi_len = s_ff.dlen;
            nxt_s.dst = D_LOW;
            ok_ev = 1'b1;
          end else begin
            err_ev = 1'b1;
          end
        end
      end
      D_LOW: begin
        if (gb_hit) begin
          guard_ev = 1'b1;
        end else if (rise) begin
          if (in_win) begin
            bit_ev = 1'b1;
            bit_val = s_ff.hi_len > s_ff.dlen;
            nxt_s.dst = D_HIGH;
            ok_ev = 1'b1;
          end else begin
            err_ev = 1'b1;
          end
        end
      end
      D_ARMED: begin
        if (release_ev) begin
          nxt_s.dst = D_HUNT;
          nxt_s.cnt = 7'h00;
        end
      end
      default: nxt_s.dst = D_IDLE;
    endcase

    // a guard band ends a message or starts a new one
    if (guard_ev) begin
      if (s_ff.dst == D_LOW && s_ff.cnt != 7'h00
          && s_ff.cnt >= s_ff.min_len[6:0]) begin
        nxt_s.dst = D_ARMED;
      end else begin
        nxt_s.cnt = 7'h00;
        nxt_s.dst = s_ff.level_mode ? D_GUARD : D_HIGH;
      end
    end
    if (err_ev) begin
      if (!s_ff.long_mode) begin
        nxt_s.dst = D_HUNT;
        nxt_s.cnt = 7'h00;
      end else begin
        nxt_s.dst = D_WAITGB;
      end
    end
    if (bit_ev) begin
      nxt_s.rx_bits = {s_ff.rx_bits[78:0], bit_val};
      if (s_ff.cnt != BUF_FULL) begin
        nxt_s.cnt = s_ff.cnt + 7'h01;
      end
    end
    if (!dec_run && s_ff.dst != D_ARMED) begin
      nxt_s.dst = D_IDLE;
    end

    // power sequencer, counting crystal ticks down to zero
    tmo = xo_tick && s_ff.scnt == 18'h00000;
    if (xo_tick && !tmo) begin
      nxt_s.scnt = s_ff.scnt - 18'h00001;
    end
    case (s_ff.sst)
      S_OFF: begin
        if (s_ff.on) begin
          nxt_s.sst = S_SYNTH;
          nxt_s.scnt = {10'h000, SYNTH_TAB[s_ff.systime[7:6]]}
                     - 18'h00001;
        end
      end
      S_SYNTH: begin
        if (tmo) begin
          nxt_s.sst = S_FAST;
          nxt_s.scnt = {10'h000, FAST_TAB[s_ff.slc[3:2]]}
                     - 18'h00001;
        end
      end
      S_FAST: begin
        if (tmo) begin
          nxt_s.edges = 4'h0;
          if (!s_ff.sniff) begin
            nxt_s.sst = S_RUN;
          end else if (s_ff.sniffc[3:0] == 4'h0) begin
            nxt_s.sst = S_AWAKE;
            nxt_s.scnt = {WAKE_TAB[s_ff.systime[2:0]], 10'h000}
                       - 18'h00001;
          end else begin
            nxt_s.sst = S_LISTEN;
            nxt_s.scnt = LISTEN_TICKS - 18'h00001;
          end
        end
      end
      S_RUN: ;
      S_LISTEN: begin
        if (err_ev || (tmo && !guard_ev && !ok_ev)) begin
          nxt_s.sst = S_SLEEP;
          nxt_s.scnt = {SLEEP_TAB[s_ff.systime[5:3]], 10'h000}
                     - 18'h00001;
        end else if (guard_ev || (ok_ev && {1'b0, s_ff.edges} + 5'h01
                     >= {1'b0, s_ff.sniffc[3:0]})) begin
          nxt_s.sst = S_AWAKE;
          nxt_s.scnt = {WAKE_TAB[s_ff.systime[2:0]], 10'h000}
                     - 18'h00001;
        end else if (ok_ev) begin
          nxt_s.edges = s_ff.edges + 4'h1;
        end
      end
      S_AWAKE: begin
        if (guard_ev) begin
          nxt_s.scnt = {WAKE_TAB[s_ff.systime[2:0]], 10'h000}
                     - 18'h00001;
        end else if (tmo && s_ff.dst != D_ARMED) begin
          nxt_s.sst = S_SLEEP;
          nxt_s.scnt = {SLEEP_TAB[s_ff.systime[5:3]], 10'h000}
                     - 18'h00001;
        end
      end
      S_SLEEP: begin
        if (tmo) begin
          nxt_s.sst = S_SYNTH;
          nxt_s.scnt = {10'h000, SYNTH_TAB[s_ff.systime[7:6]]}
                     - 18'h00001;
        end
      end
      default: nxt_s.sst = S_OFF;
    endcase
    if (!s_ff.on) begin
      nxt_s.sst = S_OFF;
    end

    // gain control; overflow pin is synchronised first
    nxt_s.ovf_s1 = gain_overflow_pin;
    nxt_s.ovf_s2 = s_ff.ovf_s1;
    nxt_s.ovf_prev = s_ff.ovf_s2;
    ovf_ev = s_ff.ovf_s2 && !s_ff.ovf_prev;
    if (ovf_ev) begin
      nxt_s.govf = 1'b1; // set wins over read clear
    end
    if (!nxt_s.gain[7] || gain_wr) begin
      nxt_s.gidx = nxt_s.gain[3:0];
    end else if (ovf_ev) begin
      if (s_ff.gidx > {2'b00, s_ff.gain[4], ~s_ff.gain[4]}) begin
        nxt_s.gidx = s_ff.gidx - {2'b00, s_ff.gain[4], ~s_ff.gain[4]};
      end else begin
        nxt_s.gidx = 4'h0;
      end
    end
    nxt_s.trim = nxt_s.gain[7] ? {nxt_s.gain[6:4], nxt_s.gidx}
                               : nxt_s.gain[6:0];

    // registered outputs
    nxt_s.aon = !(nxt_s.sst == S_OFF || nxt_s.sst == S_SLEEP)
             || nxt_s.sniffc[5];
    nxt_s.asleep = nxt_s.sst == S_SLEEP;
    nxt_s.irq = nxt_s.dst == D_ARMED;
    case (nxt_s.sniffc[7:6])
      2'b00:   nxt_s.rt = xo_tick;
      2'b01:   nxt_s.rt = dec_tick;
      2'b10:   nxt_s.rt = slicer_bit;
      default: nxt_s.rt = nxt_s.aon;
    endcase
  end

  // ==========================================================
  // state register with presets
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_ff <= '0;
      s_ff.min_len <= RST_MIN_LEN;
      s_ff.gain <= RST_GAIN;
      s_ff.slc <= RST_SLICER;
      s_ff.systime <= RST_SYSTIME;
      s_ff.dcd <= RST_DCD;
      s_ff.sniffc <= RST_SNIFF;
      s_ff.dst <= D_IDLE;
      s_ff.sst <= S_OFF;
      s_ff.gidx <= RST_GAIN[3:0];
      s_ff.trim <= RST_GAIN[6:0];
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rd_data         = s_ff.rdata;
  assign msg_irq         = s_ff.irq;
  assign gain_trim       = s_ff.trim;
  assign analog_on       = s_ff.aon;
  assign receiver_asleep = s_ff.asleep;
  assign rt_out          = s_ff.rt;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_buf_shift: assert property (
    bit_ev |=> s_ff.rx_bits[0] == $past(bit_val)
           && s_ff.rx_bits[79:1] == $past(s_ff.rx_bits[78:0]))
    else $error("bit buffer did not shift in the new bit");

  chk_count_max: assert property (
    s_ff.cnt <= BUF_FULL)
    else $error("bit count above buffer size");

  chk_count_step: assert property (
    bit_ev && s_ff.cnt < BUF_FULL && !guard_ev && !err_ev
      |=> s_ff.cnt == $past(s_ff.cnt) + 7'h01)
    else $error("bit count did not step");

  chk_armed_hold: assert property (
    s_ff.dst == D_ARMED && !release_ev |=> s_ff.dst == D_ARMED
      && $stable(s_ff.rx_bits) && $stable(s_ff.cnt) && msg_irq)
    else $error("armed state not held");

  chk_ready_read: assert property (
    rd_en && addr == ADDR_STATUS |=>
      rd_data[ST_READY] == ($past(s_ff.dst) == D_ARMED))
    else $error("ready bit does not match armed state");

  chk_release: assert property (
    s_ff.dst == D_ARMED && wr_en && addr == ADDR_STATUS
      && !wr_data[ST_READY] |=> s_ff.dst == D_HUNT && s_ff.cnt == 7'h00
      ##1 !msg_irq)
    else $error("release from armed failed");

  chk_long_mode: assert property (
    err_ev |=> s_ff.dst == ($past(s_ff.long_mode) ? D_WAITGB : D_HUNT))
    else $error("long element handling wrong");

  chk_min_len: assert property (
    $rose(s_ff.dst == D_ARMED) |-> s_ff.cnt >= s_ff.min_len[6:0]
      && s_ff.cnt != 7'h00)
    else $error("message armed below minimum length");

  chk_trim_fixed: assert property (
    !s_ff.gain[7] |-> gain_trim == s_ff.gain[6:0])
    else $error("fixed gain not driven to trim");

  chk_sniff_sleep: assert property (
    s_ff.sst == S_LISTEN && err_ev && s_ff.on |=> receiver_asleep
      && s_ff.sst == S_SLEEP)
    else $error("mistimed sniff element did not sleep");

  chk_reset_vals: assert property (
    $fell(sys_rst) |-> s_ff.min_len == RST_MIN_LEN
      && s_ff.dcd == RST_DCD && s_ff.systime == RST_SYSTIME)
    else $error("presets missing after reset");

  cov_armed: cover property ($rose(s_ff.dst == D_ARMED));
  cov_sleep: cover property ($rose(s_ff.sst == S_SLEEP));
  cov_awake: cover property ($rose(s_ff.sst == S_AWAKE));
  cov_full:  cover property (bit_ev && s_ff.cnt == BUF_FULL);
endmodule : ookrx_core

// [testbench/ookrx_tx_model.sv]
`timescale 1ns/1ps
module ookrx_tx_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [7:0]  pat,
  output logic             mag_valid,
  output logic [15:0]      mag_sample
);
  logic [15:0] amp;

  // ========
  // hold one level for n decimated samples of sixteen inputs
  task automatic seg(input logic hi, input int n);
    repeat (n * 16) begin
      @(posedge clk);
      mag_sample <= hi ? amp : 16'h0000;
    end
  endtask : seg

  // guard, eight 1/3-2/3 symbols msb first, end mark, guard, edge
  initial begin
    mag_valid  = 1'b1;
    mag_sample = 16'h0000;
    amp        = 16'h3000;
    @(posedge go);
    amp = 16'h3000 + 16'($urandom % 4096);
    seg(1'b0, 64);
    for (int i = 7; i >= 0; i--) begin
      seg(1'b1, pat[i] ? 16 : 8);
      seg(1'b0, pat[i] ? 8 : 16);
    end
    seg(1'b1, 12);
    seg(1'b0, 64);
    seg(1'b1, 16);
    seg(1'b0, 1);
  end
endmodule : ookrx_tx_model

// [testbench/ook_rx_decoder_control_tb_top.sv]
`timescale 1ns/1ps
module ook_rx_decoder_control_tb_top;
  import ookrx_pkg::*;
  logic        clk, sys_rst, wr_en, rd_en, go, mv, irq, rdv, ovf, aon, slp;
  logic [31:0] addr;
  logic [7:0]  wd, rdd, pat;
  logic [15:0] ms, n;
  logic [6:0]  trim;
  logic [15:0] q[$];
  int          errors, compares, cyc;
  logic [31:0] ra[6] = '{ADDR_MIN_LEN, ADDR_GAIN, ADDR_SLICER,
                         ADDR_SYSTIME, ADDR_DCD_LO, ADDR_DCD_HI};
  logic [7:0]  rv[6] = '{RST_MIN_LEN, RST_GAIN, RST_SLICER,
                         RST_SYSTIME, RST_DCD[7:0], RST_DCD[15:8]};

  ookrx_core #(.XO_TICK_CYCLES(4)) dut (.clk(clk), .sys_rst(sys_rst),
    .addr(addr), .wr_data(wd), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rdd), .mag_valid(mv), .mag_sample(ms),
    .gain_overflow_pin(ovf), .msg_irq(irq), .gain_trim(trim),
    .analog_on(aon), .receiver_asleep(slp), .rt_out());
  ookrx_tx_model tx (.clk(clk), .go(go), .pat(pat), .mag_valid(mv),
    .mag_sample(ms));

  // ========
  // compare, report and close
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: exp %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // ========
  // register bus master, reads note the masked expectation
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wd    <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    q.push_back({m, e & m});
    @(posedge clk);
    rd_en <= 1'b0;
  endtask : rd

  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // read data stands the cycle after the strobe; timeout
  always @(posedge clk) begin
    if (rdv) begin
      n = q.pop_front();
      chk(n[7:0], rdd & n[15:8]);
    end
    rdv <= rd_en;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    {sys_rst, wr_en, rd_en, go, rdv, ovf} = 6'b100000;
    addr = 32'h0;
    wd   = 8'h00;
    {cyc, errors, compares} = '0;
    void'($urandom(32'h43186da8));
    pat = 8'($urandom);
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(ra[i], rv[i], 8'hff);
    chk(8'h18, {1'b0, trim});
    wr(ADDR_GAIN, 8'h35);
    repeat (2) @(negedge clk);
    chk(8'h35, {1'b0, trim});
    wr(ADDR_BIT_COUNT, 8'h7f);
    rd(ADDR_BIT_COUNT, 8'h00, 8'hff);
    rd(32'h5001_1010, 8'h00, 8'hff);
    // auto gain: one overflow edge steps the index down by two
    wr(ADDR_GAIN, RST_GAIN);
    ovf <= 1'b1;
    repeat (6) @(negedge clk);
    chk(8'h16, {1'b0, trim});
    rd(ADDR_STATUS, 8'h10, 8'hf0);
    rd(ADDR_STATUS, 8'h00, 8'hf0);
    ovf <= 1'b0;
    wr(ADDR_MIN_LEN, 8'h08);
    wr(ADDR_STATUS, 8'h80);
    rd(ADDR_STATUS, 8'h80, 8'he0);
    chk(8'h01, {7'h00, aon});
    repeat (600) @(posedge clk);
    go <= 1'b1;
    for (int i = 0; i < 9000 && irq !== 1'b1; i++) @(posedge clk);
    chk(8'h01, {7'h00, irq});
    rd(ADDR_STATUS, 8'ha0, 8'he0);
    rd(ADDR_BIT_COUNT, 8'h08, 8'hff);
    rd(ADDR_BUF_FIRST, pat, 8'hff);
    wr(ADDR_STATUS, 8'h80);
    repeat (3) @(negedge clk);
    chk(8'h00, {7'h00, irq});
    rd(ADDR_STATUS, 8'h80, 8'he0);
    rd(ADDR_BIT_COUNT, 8'h00, 8'hff);
    // sniff with no signal: listen times out, then sleep
    wr(ADDR_STATUS, 8'h00);
    wr(ADDR_STATUS, 8'hc0);
    repeat (700) @(posedge clk);
    chk(8'h01, {7'h00, slp});
    chk(8'h00, {7'h00, aon});
    rd(ADDR_STATUS, 8'hc1, 8'he1);
    // reset in mid-run brings the presets back
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_MIN_LEN, RST_MIN_LEN, 8'hff);
    rd(ADDR_STATUS, 8'h00, 8'hff);
    repeat (2) @(posedge clk);
    wrap_up();
  end
endmodule : ook_rx_decoder_control_tb_top
